// File: rtl/token_node_status_flags.sv
// status flag register bank of a token-passing node with a Wishbone slave
// assumes the receive and transmit engines run on clk_sys and give one-cycle pulses
`timescale 1ns/1ps
`include "token_node_status_params.svh"
module token_node_status_flags #(
    parameter int unsigned IDLE_CYCLES = `TNS_IDLE_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // serial line and link engine
    input wire logic serialRxIn,
    input wire logic rxPacketStored,
    input wire logic rxSendAttempt,
    input wire logic tokenToUs,
    input wire logic lastByteSent,
    input wire logic txAckIn,
    input wire logic txBroadcast,
    output logic rxNakOut,
    output logic rxEnableOut,
    output logic txRequestOut,
    // interrupt
    output logic irqOut
);
    localparam int unsigned CW = $clog2(IDLE_CYCLES + 1);
    localparam logic [CW-1:0] IDLE_LAST = CW'(IDLE_CYCLES - 1);

    // serial line synchroniser and activity detect
    logic rxMeta_r, rxSync_r, rxPrev_r;
    logic [CW-1:0] idleCnt_r, idleCnt_nxt;
    logic idleExpire;

    // flags and transmit state
    logic rxBlk_r, rxBlk_nxt;
    logic rstOcc_r, rstOcc_nxt;
    logic rebuild_r, rebuild_nxt;
    logic txAck_r, txAck_nxt;
    logic txFree_r, txFree_nxt;
    logic ackWin_r, ackWin_nxt;
    logic bcast_r, bcast_nxt;
    token_node_status_pkg::tx_state_e txState_r, txState_nxt;
    logic [7:0] statusNow;

    // software registers and bus
    logic [7:0] mask_r, mask_nxt;
    logic [7:0] nodeId_r, nodeId_nxt;
    logic [7:0] event_r, event_nxt;
    logic [31:0] datO_nxt;
    logic ack_nxt, irq_nxt, nak_nxt;
    logic wbReq, wrLow, armCmd, clrCmd, sendCmd, disCmd, softRst, nodeZero, rdEvent;
    logic [7:0] prevIrqFlags_r;

    assign wbReq = cyc_i && stb_i && !ack_o;
    assign wrLow = wbReq && we_i && sel_i[0];
    assign armCmd = wrLow && adr_i == `TNS_ADR_CMD && dat_i[`TNS_CMD_ARM_RX];
    assign clrCmd = wrLow && adr_i == `TNS_ADR_CMD && dat_i[`TNS_CMD_FLAG_CLEAR];
    assign sendCmd = wrLow && adr_i == `TNS_ADR_CMD && dat_i[`TNS_CMD_SEND];
    assign disCmd = wrLow && adr_i == `TNS_ADR_CMD && dat_i[`TNS_CMD_TX_DISABLE];
    assign softRst = wrLow && adr_i == `TNS_ADR_CMD && dat_i[`TNS_CMD_SOFT_RESET];
    assign nodeZero = wrLow && adr_i == `TNS_ADR_NODEID && dat_i[7:0] == 8'h00;
    assign rdEvent = wbReq && !we_i && adr_i == `TNS_ADR_EVENT;
    assign idleExpire = idleCnt_r == IDLE_LAST;
    // reserved bits 6, 5 and the test bit read as zero
    assign statusNow = {rxBlk_r, 2'b00, rstOcc_r, 1'b0, rebuild_r, txAck_r, txFree_r};

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rxMeta_r <= 1'b0;
            rxSync_r <= 1'b0;
            rxPrev_r <= 1'b0;
        end
        else
        begin
            rxMeta_r <= serialRxIn;
            rxSync_r <= rxMeta_r;
            rxPrev_r <= rxSync_r;
        end
    end

    // line idle timer, restarted by any edge on the line
    always_comb
    begin
        if (rxSync_r != rxPrev_r || idleExpire)
            idleCnt_nxt = '0;
        else
            idleCnt_nxt = idleCnt_r + CW'(1);
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            idleCnt_r <= '0;
        else
            idleCnt_r <= idleCnt_nxt;
    end

    // flags: every hardware set wins over a clear in the same cycle, but a soft reset wins over every hardware set
    always_comb
    begin
        rxBlk_nxt = rxBlk_r;
        rstOcc_nxt = rstOcc_r;
        rebuild_nxt = rebuild_r;
        txAck_nxt = txAck_r;
        txFree_nxt = txFree_r;
        ackWin_nxt = ackWin_r;
        bcast_nxt = bcast_r;
        txState_nxt = txState_r;
        if (armCmd)
            rxBlk_nxt = 1'b0;
        if (rxPacketStored)
            rxBlk_nxt = 1'b1;
        if (clrCmd)
        begin
            rstOcc_nxt = 1'b0;
            rebuild_nxt = 1'b0;
        end
        if (nodeZero)
            rstOcc_nxt = 1'b1;
        if (idleExpire)
            rebuild_nxt = 1'b1;
        case (txState_r)
            token_node_status_pkg::TX_WAIT_TOKEN:
            begin
                if (tokenToUs)
                begin
                    txFree_nxt = 1'b0;
                    ackWin_nxt = 1'b1;
                    bcast_nxt = txBroadcast;
                    txState_nxt = token_node_status_pkg::TX_SENDING;
                end
            end
            token_node_status_pkg::TX_SENDING:
            begin
                if (lastByteSent)
                begin
                    txFree_nxt = 1'b1;
                    txState_nxt = token_node_status_pkg::TX_IDLE;
                end
            end
            default: txState_nxt = token_node_status_pkg::TX_IDLE;
        endcase
        if (sendCmd)
        begin
            txAck_nxt = 1'b0;
            ackWin_nxt = 1'b0;
            txState_nxt = token_node_status_pkg::TX_WAIT_TOKEN;
        end
        if (disCmd)
        begin
            txFree_nxt = 1'b1;
            txState_nxt = token_node_status_pkg::TX_IDLE;
        end
        if (txAckIn && ackWin_r && !bcast_r)
            txAck_nxt = 1'b1;
        if (softRst)
        begin
            rxBlk_nxt = 1'(`TNS_STATUS_RESET >> `TNS_BIT_RECEIVE_BLOCKED);
            rstOcc_nxt = 1'b1;
            rebuild_nxt = 1'b0;
            txAck_nxt = 1'b0;
            txFree_nxt = 1'b1;
            ackWin_nxt = 1'b0;
            bcast_nxt = 1'b0;
            txState_nxt = token_node_status_pkg::TX_IDLE;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rxBlk_r <= 1'(`TNS_STATUS_RESET >> `TNS_BIT_RECEIVE_BLOCKED);
            rstOcc_r <= 1'b1;
            rebuild_r <= 1'b0;
            txAck_r <= 1'b0;
            txFree_r <= 1'b1;
            ackWin_r <= 1'b0;
            bcast_r <= 1'b0;
            txState_r <= token_node_status_pkg::TX_IDLE;
        end
        else
        begin
            rxBlk_r <= rxBlk_nxt;
            rstOcc_r <= rstOcc_nxt;
            rebuild_r <= rebuild_nxt;
            txAck_r <= txAck_nxt;
            txFree_r <= txFree_nxt;
            ackWin_r <= ackWin_nxt;
            bcast_r <= bcast_nxt;
            txState_r <= txState_nxt;
        end
    end

    // bus slave, sticky events and outputs
    always_comb
    begin
        mask_nxt = mask_r;
        nodeId_nxt = nodeId_r;
        datO_nxt = dat_o;
        ack_nxt = wbReq;
        // rising interrupt-capable flags are latched; a read of the event word clears
        event_nxt = rdEvent ? 8'h00 : event_r;
        event_nxt = event_nxt | (statusNow & ~prevIrqFlags_r & `TNS_IRQ_BITS);
        if (wrLow)
        begin
            if (adr_i == `TNS_ADR_MASK)
                mask_nxt = dat_i[7:0];
            else if (adr_i == `TNS_ADR_NODEID)
                nodeId_nxt = dat_i[7:0];
        end
        if (wbReq && !we_i)
        begin
            if (adr_i == `TNS_ADR_STATUS)
                datO_nxt = {24'h000000, statusNow};
            else if (adr_i == `TNS_ADR_MASK)
                datO_nxt = {24'h000000, mask_r};
            else if (adr_i == `TNS_ADR_NODEID)
                datO_nxt = {24'h000000, nodeId_r};
            else if (adr_i == `TNS_ADR_EVENT)
                datO_nxt = {24'h000000, event_r};
            else
                datO_nxt = 32'h00000000;
        end
        irq_nxt = |(statusNow & mask_r & `TNS_IRQ_BITS) || |(event_r & mask_r);
        nak_nxt = rxSendAttempt && rxBlk_r;
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mask_r <= `TNS_MASK_RESET;
            nodeId_r <= `TNS_NODEID_RESET;
            event_r <= 8'h00;
            prevIrqFlags_r <= 8'h00;
            dat_o <= 32'h00000000;
            ack_o <= 1'b0;
            irqOut <= 1'b0;
            rxNakOut <= 1'b0;
            rxEnableOut <= 1'b0;
            txRequestOut <= 1'b0;
        end
        else
        begin
            mask_r <= mask_nxt;
            nodeId_r <= nodeId_nxt;
            event_r <= event_nxt;
            prevIrqFlags_r <= statusNow & `TNS_IRQ_BITS;
            dat_o <= datO_nxt;
            ack_o <= ack_nxt;
            irqOut <= irq_nxt;
            rxNakOut <= nak_nxt;
            rxEnableOut <= !rxBlk_nxt;
            txRequestOut <= txState_nxt == token_node_status_pkg::TX_WAIT_TOKEN;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    sequence s_tokenTaken;
        tokenToUs && !sendCmd && !disCmd && !softRst;
    endsequence

    property p_rxStoredBlocks;
        rxPacketStored |=> rxBlk_r && !rxEnableOut;
    endproperty
    a_rxStoredBlocks: assert property (p_rxStoredBlocks) else $error("packet did not block rx");
    property p_armClears;
        armCmd && !rxPacketStored && !softRst |=> !rxBlk_r ##0 rxEnableOut;
    endproperty
    a_armClears: assert property (p_armClears) else $error("arm did not clear block");
    property p_irqLevel;
        |(statusNow & mask_r & `TNS_IRQ_BITS) |=> irqOut;
    endproperty
    a_irqLevel: assert property (p_irqLevel) else $error("masked flag gave no irq");
    property p_nak;
        rxSendAttempt |=> rxNakOut == $past(rxBlk_r);
    endproperty
    a_nak: assert property (p_nak) else $error("nak does not follow rx block");
    property p_nodeZero;
        nodeZero |=> rstOcc_r;
    endproperty
    a_nodeZero: assert property (p_nodeZero) else $error("node id zero missed reset flag");
    property p_rstOccHold;
        rstOcc_r && !clrCmd |=> rstOcc_r;
    endproperty
    a_rstOccHold: assert property (p_rstOccHold) else $error("reset flag lost without clear");
    property p_zeroBits;
        ack_o && $past(adr_i) == `TNS_ADR_STATUS && !$past(we_i)
            |-> dat_o[6:5] == 2'b00 && !dat_o[3];
    endproperty
    a_zeroBits: assert property (p_zeroBits) else $error("reserved or test bit set");
    property p_rebuild;
        idleExpire && !softRst |=> rebuild_r;
    endproperty
    a_rebuild: assert property (p_rebuild) else $error("idle expiry missed rebuild");
    property p_rebuildClr;
        clrCmd && !idleExpire |=> !rebuild_r;
    endproperty
    a_rebuildClr: assert property (p_rebuildClr) else $error("clear left rebuild set");
    property p_noBcastAck;
        $rose(txAck_r) |-> !bcast_r;
    endproperty
    a_noBcastAck: assert property (p_noBcastAck) else $error("broadcast acknowledged");
    property p_tokenClearsFree;
        txState_r == token_node_status_pkg::TX_WAIT_TOKEN ##0 s_tokenTaken |=> !txFree_r;
    endproperty
    a_tokenClearsFree: assert property (p_tokenClearsFree) else $error("token kept tx free");
    property p_lastByteFree;
        txState_r == token_node_status_pkg::TX_SENDING && lastByteSent |=> txFree_r;
    endproperty
    a_lastByteFree: assert property (p_lastByteFree) else $error("last byte left tx busy");
    property p_softReset;
        softRst |=> statusNow == `TNS_STATUS_RESET;
    endproperty
    a_softReset: assert property (p_softReset) else $error("soft reset value wrong");

endmodule : token_node_status_flags

// File: rtl/token_node_status_params.svh
// constants for the token node status flag register bank
// assumes a 100 MHz system clock and a 32-bit classic Wishbone register bus
`ifndef TOKEN_NODE_STATUS_PARAMS_SVH
`define TOKEN_NODE_STATUS_PARAMS_SVH
`define TNS_ADR_STATUS 8'h00
`define TNS_ADR_MASK 8'h04
`define TNS_ADR_CMD 8'h08
`define TNS_ADR_NODEID 8'h0C
`define TNS_ADR_EVENT 8'h10
`define TNS_BIT_RECEIVE_BLOCKED 7
`define TNS_BIT_RESET_OCCURRED 4
`define TNS_BIT_TEST 3
`define TNS_BIT_REBUILD 2
`define TNS_BIT_TX_ACKED 1
`define TNS_BIT_TX_FREE 0
`define TNS_CMD_ARM_RX 0
`define TNS_CMD_FLAG_CLEAR 1
`define TNS_CMD_SEND 2
`define TNS_CMD_TX_DISABLE 3
`define TNS_CMD_SOFT_RESET 4
`define TNS_STATUS_RESET 8'h91
`define TNS_IRQ_BITS 8'h85
`define TNS_MASK_RESET 8'h00
`define TNS_NODEID_RESET 8'h00
`define TNS_IDLE_NS 41000
`define TNS_CLK_NS 10
`define TNS_IDLE_CYCLES ((`TNS_IDLE_NS + `TNS_CLK_NS - 1) / `TNS_CLK_NS)
`endif

// File: rtl/token_node_status_pkg.sv
// types shared by the token node status flag register bank
// assumes the constants header for all numeric values except the one-hot state encodings defined here
package token_node_status_pkg;
    typedef enum logic [2:0]
    {
        TX_IDLE = 3'b001,
        TX_WAIT_TOKEN = 3'b010,
        TX_SENDING = 3'b100
    } tx_state_e;
endpackage : token_node_status_pkg

// File: sim/token_node_link_model.sv
// behavioural model of the other nodes and link engine around the status block
// assumes the bench calls its tasks from a process synchronised to clk_sys
`timescale 1ns/1ps
module token_node_link_model (
    // clock
    input wire logic clk_sys,
    // line and link events toward the block
    output logic serialRxIn,
    output logic rxPacketStored,
    output logic rxSendAttempt,
    output logic tokenToUs,
    output logic lastByteSent,
    output logic txAckIn,
    output logic txBroadcast
);
    logic [4:0] pulseR;
    logic lineR;
    logic lineIdle;
    logic bcastR;

    initial
    begin
        pulseR = 5'h00;
        lineIdle = 1'b0;
        bcastR = 1'b0;
    end

    assign {txAckIn, lastByteSent, tokenToUs, rxSendAttempt, rxPacketStored} = pulseR;
    assign serialRxIn = lineR;
    assign txBroadcast = bcastR;

    // traffic keeps the line toggling; an idle line holds its level
    initial
    begin
        lineR = 1'b0;
        forever
        begin
            @(posedge clk_sys);
            if (!lineIdle)
                lineR <= ~lineR;
        end
    end

    // 0 stored, 1 send attempt, 2 token, 3 last byte, 4 acknowledge
    task pulse(input int unsigned which);
        @(posedge clk_sys);
        pulseR[which] <= 1'b1;
        @(posedge clk_sys);
        pulseR <= 5'h00;
    endtask : pulse

    task setIdle(input logic v);
        @(posedge clk_sys);
        lineIdle <= v;
    endtask : setIdle

    task setBroadcast(input logic v);
        @(posedge clk_sys);
        bcastR <= v;
    endtask : setBroadcast
endmodule : token_node_link_model

// File: sim/token_node_status_flags_bench.sv
// self-checking bench for the token node status flag register bank
// assumes the link model file and the design files are compiled first
`timescale 1ns/1ps
module token_node_status_flags_bench;
    logic clk_sys;
    logic sys_rst;
    logic cyc, stb, we;
    logic [7:0] adr;
    logic [3:0] sel, selNow;
    logic [31:0] datW, datR, rd;
    logic ack, serialRxIn, rxPacketStored, rxSendAttempt, tokenToUs, lastByteSent;
    logic txAckIn, txBroadcast, rxNakOut, rxEnableOut, txRequestOut, irqOut;
    int badCount = 0, samplesChecked = 0;

    token_node_status_flags #(.IDLE_CYCLES(20)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datW),
        .dat_o(datR), .ack_o(ack), .serialRxIn(serialRxIn), .rxPacketStored(rxPacketStored),
        .rxSendAttempt(rxSendAttempt), .tokenToUs(tokenToUs), .lastByteSent(lastByteSent),
        .txAckIn(txAckIn), .txBroadcast(txBroadcast), .rxNakOut(rxNakOut),
        .rxEnableOut(rxEnableOut), .txRequestOut(txRequestOut), .irqOut(irqOut));

    token_node_link_model link (.clk_sys(clk_sys), .serialRxIn(serialRxIn),
        .rxPacketStored(rxPacketStored), .rxSendAttempt(rxSendAttempt),
        .tokenToUs(tokenToUs), .lastByteSent(lastByteSent), .txAckIn(txAckIn),
        .txBroadcast(txBroadcast));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task giveVerdict;
        if (badCount == 0 && samplesChecked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : giveVerdict

    task check(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            badCount++;
        end
    endtask : check

    task wbCycle(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        datW <= d;
        sel <= selNow;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        rd = datR;
        if (n >= 50)
            check(32'hDEAD_0000, {24'h000000, a});
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wbCycle

    task expStatus(input logic [7:0] e);
        wbCycle(8'h00, 1'b0, 32'h0000_0000);
        check(rd, {24'h000000, e});
    endtask : expStatus

    task cmd(input logic [7:0] c);
        wbCycle(8'h08, 1'b1, {24'h000000, c});
    endtask : cmd

    task rxScen;
        expStatus(8'h91);
        check({31'h0, rxEnableOut}, 32'h0);
        cmd(8'h01);
        expStatus(8'h11);
        check({31'h0, rxEnableOut}, 32'h1);
        link.pulse(1);
        @(posedge clk_sys);
        check({31'h0, rxNakOut}, 32'h0);
        link.pulse(0);
        expStatus(8'h91);
        link.pulse(1);
        @(posedge clk_sys);
        check({31'h0, rxNakOut}, 32'h1);
    endtask : rxScen

    task flagScen;
        cmd(8'h02);
        expStatus(8'h81);
        wbCycle(8'h0C, 1'b1, 32'h0000_0005);
        expStatus(8'h81);
        wbCycle(8'h0C, 1'b1, 32'h0000_0000);
        expStatus(8'h91);
        cmd(8'h02);
        link.setIdle(1'b1);
        repeat (12) @(posedge clk_sys);
        expStatus(8'h81);
        repeat (15) @(posedge clk_sys);
        link.setIdle(1'b0);
        expStatus(8'h85);
        cmd(8'h02);
        expStatus(8'h81);
    endtask : flagScen

    task txRun(input logic bc, input logic [7:0] acked);
        link.setBroadcast(bc);
        cmd(8'h04);
        check({31'h0, txRequestOut}, 32'h1);
        expStatus(8'h81);
        link.pulse(2);
        expStatus(8'h80);
        link.pulse(3);
        expStatus(8'h81);
        link.pulse(4);
        expStatus(acked);
        link.setBroadcast(1'b0);
    endtask : txRun

    task txScen;
        txRun(1'b0, 8'h83);
        txRun(1'b1, 8'h81);
        cmd(8'h04);
        link.pulse(2);
        expStatus(8'h80);
        cmd(8'h08);
        expStatus(8'h81);
    endtask : txScen

    task irqMask(input logic [7:0] m, input logic e);
        wbCycle(8'h04, 1'b1, {24'h000000, m});
        repeat (2) @(posedge clk_sys);
        check({31'h0, irqOut}, {31'h0, e});
    endtask : irqMask

    task irqScen;
        wbCycle(8'h10, 1'b0, 32'h0000_0000);
        irqMask(8'h00, 1'b0);
        irqMask(8'h04, 1'b0);
        irqMask(8'h01, 1'b1);
        irqMask(8'h80, 1'b1);
        irqMask(8'h04, 1'b0);
        link.setIdle(1'b1);
        repeat (30) @(posedge clk_sys);
        check({31'h0, irqOut}, 32'h1);
        link.setIdle(1'b0);
        cmd(8'h02);
        wbCycle(8'h10, 1'b0, 32'h0000_0000);
        check(rd, 32'h0000_0004);
        repeat (2) @(posedge clk_sys);
        check({31'h0, irqOut}, 32'h0);
    endtask : irqScen

    task regScen;
        wbCycle(8'h20, 1'b0, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        wbCycle(8'h00, 1'b1, 32'h0000_00FF);
        expStatus(8'h81);
        selNow = 4'hE;
        wbCycle(8'h04, 1'b1, 32'h0000_00FF);
        selNow = 4'hF;
        wbCycle(8'h04, 1'b0, 32'h0000_0000);
        check(rd, 32'h0000_0004);
        cmd(8'h10);
        expStatus(8'h91);
        cmd(8'h03);
        expStatus(8'h01);
        wbCycle(8'h04, 1'b1, 32'h0000_0085);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        expStatus(8'h91);
        wbCycle(8'h04, 1'b0, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        check({31'h0, irqOut}, 32'h0);
    endtask : regScen

    initial
    begin
        sys_rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        selNow = 4'hF;
        datW = 32'h0000_0000;
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rxScen();
        flagScen();
        txScen();
        irqScen();
        regScen();
        giveVerdict();
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        badCount++;
        giveVerdict();
    end
endmodule : token_node_status_flags_bench
